// >>> pkg/cag_pkg.sv
// Constants and types for the coprocessor access gate.
// Assumes a single core clock and a synchronous active-high reset.
package cag_pkg;
   localparam int unsigned WORD_W = 32;
   // System control coprocessor selector of the access control register.
   localparam logic [3:0] SEL_CRN = 4'h1;
   localparam logic [2:0] SEL_OP1 = 3'h0;
   localparam logic [3:0] SEL_CRM = 4'h0;
   localparam logic [3:0] SEL_CRM_NONSECURE = 4'h1;
   localparam logic [2:0] SEL_OP2 = 3'h2;
   // Field layout of coproc_access_control.
   localparam int unsigned SIMD_ONLY_DISABLE_BIT = 31;
   localparam int unsigned UPPER_DREG_DISABLE_BIT = 30;
   localparam int unsigned HIGH_PERM_LSB = 22;
   localparam int unsigned LOW_PERM_LSB = 20;
   localparam logic [31:0] ACCESS_CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] DISABLE_MASK = 32'hc000_0000;
   localparam logic [31:0] HIGH_PERM_MASK = 32'h00c0_0000;
   localparam logic [31:0] LOW_PERM_MASK = 32'h0030_0000;
   // Permission field encodings.
   localparam logic [1:0] PERM_DENIED = 2'h0;
   localparam logic [1:0] PERM_PRIV_ONLY = 2'h1;
   localparam logic [1:0] PERM_RESERVED = 2'h2;
   localparam logic [1:0] PERM_FULL = 2'h3;
   // Operand formats an instruction may name.
   typedef enum logic [3:0] {
      FMT_INT8, FMT_INT16, FMT_INT32, FMT_INT64, FMT_HALF, FMT_SINGLE,
      FMT_DOUBLE, FMT_POLY8, FMT_POLY16
   } fmt_e;
   // Half precision field widths, half and single exponent limits and half special encodings.
   localparam int unsigned HALF_EXP_W = 5;
   localparam int unsigned HALF_MAN_W = 10;
   localparam logic [4:0] HALF_EXP_MAX = 5'h1f;
   localparam logic [7:0] SINGLE_EXP_MAX = 8'hff;
   localparam logic [7:0] EXP_REBIAS = 8'h70;
   localparam logic [7:0] HALF_EXP_TOP_IEEE = 8'h8e;
   localparam logic [7:0] HALF_EXP_TOP_ALT = 8'h8f;
   localparam logic [15:0] HALF_INF = 16'h7c00;
   localparam logic [15:0] HALF_QNAN = 16'h7e00;
   localparam logic [15:0] HALF_ALT_MAX = 16'h7fff;
endpackage

// >>> pkg/conv_if.sv
// Carrier between the gate and its half-precision converter.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface conv_if;
   logic req;
   logic to_single;
   logic alt_half;
   logic [31:0] operand;
   logic done;
   logic [31:0] result;
   modport requester (output req, output to_single, output alt_half, output operand,
      input done, input result);
   modport converter (input req, input to_single, input alt_half, input operand,
      output done, output result);
endinterface

// >>> rtl/half_converter.sv
// Half to single and single to half precision converter, one cycle latency.
// Assumes requests come from logic on the same clock; one result per request.
`timescale 1ns/1ps
module half_converter (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Request and result
   conv_if.converter cv
);
   import cag_pkg::*;

   logic done_q, done_d;
   logic [31:0] result_q, result_d;
   logic sign;
   logic [4:0] hexp;
   logic [9:0] hman;
   logic [7:0] sexp;
   logic [22:0] sman;
   logic [9:0] norm_man;
   logic [7:0] norm_exp;
   logic found;
   logic [7:0] top_exp;

   assign cv.done = done_q;
   assign cv.result = result_q;

   always_comb begin
      done_d = cv.req;
      result_d = result_q;
      sign = cv.to_single ? cv.operand[15] : cv.operand[31];
      hexp = cv.operand[14:10];
      hman = cv.operand[9:0];
      sexp = cv.operand[30:23];
      sman = cv.operand[22:0];
      norm_man = '0;
      norm_exp = '0;
      found = 1'b0;
      // Normalise a half subnormal by finding its leading one.
      for (int i = HALF_MAN_W - 1; i >= 0; i--) begin
         if (!found && hman[i]) begin
            found = 1'b1;
            norm_man = 10'(hman << (HALF_MAN_W - i));
            norm_exp = 8'(EXP_REBIAS + 8'(i) - 8'(HALF_MAN_W - 1));
         end
      end
      top_exp = cv.alt_half ? HALF_EXP_TOP_ALT : HALF_EXP_TOP_IEEE;
      if (cv.req && cv.to_single) begin
         // The alternative format has no infinity or NaN in its top exponent.
         if (hexp == '0) begin
            result_d = (hman == '0) ? {sign, 31'h0} : {sign, norm_exp, norm_man, 13'h0};
         end else if (hexp == HALF_EXP_MAX && !cv.alt_half) begin
            result_d = {sign, SINGLE_EXP_MAX, hman, 13'h0};
         end else begin
            result_d = {sign, 8'(8'(hexp) + EXP_REBIAS), hman, 13'h0};
         end
      end else if (cv.req) begin
         // Rounds toward zero; results below the normal half range flush to zero.
         result_d[31:16] = '0;
         if (sexp == SINGLE_EXP_MAX) begin
            if (cv.alt_half) begin
               result_d[15:0] = (sman == '0) ? (HALF_ALT_MAX | {sign, 15'h0}) : 16'h0;
            end else begin
               result_d[15:0] = (sman == '0) ? (HALF_INF | {sign, 15'h0}) : HALF_QNAN;
            end
         end else if (sexp > top_exp) begin
            result_d[15:0] = cv.alt_half ? (HALF_ALT_MAX | {sign, 15'h0})
                                         : (HALF_INF | {sign, 15'h0});
         end else if (sexp <= EXP_REBIAS) begin
            result_d[15:0] = {sign, 15'h0};
         end else begin
            result_d[15:0] = {sign, 5'(sexp - EXP_REBIAS), sman[22:13]};
         end
      end
      if (rst_i) begin
         done_d = 1'b0;
         result_d = '0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      done_q <= done_d;
      result_q <= result_d;
   end
endmodule

// >>> rtl/coprocessor_access_gate.sv
// Access-permission gate for the floating-point and SIMD coprocessors.
// Assumes the decoder, exception logic and control-coprocessor port share sys_clk_i.
`timescale 1ns/1ps
module coprocessor_access_gate #(
   parameter bit LOW_IMPLEMENTED = 1'b1,
   parameter bit HIGH_IMPLEMENTED = 1'b1
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // System control coprocessor register port
   input wire logic sc_valid_i,
   input wire logic sc_write_i,
   input wire logic sc_priv_i,
   input wire logic [3:0] sc_crn_i,
   input wire logic [2:0] sc_op1_i,
   input wire logic [3:0] sc_crm_i,
   input wire logic [2:0] sc_op2_i,
   input wire logic [cag_pkg::WORD_W-1:0] sc_wdata_i,
   output logic sc_hit_o,
   output logic sc_undef_o,
   output logic [cag_pkg::WORD_W-1:0] sc_rdata_o,
   // Barrier and global enable from the core
   input wire logic isb_i,
   input wire logic fp_global_enable_i,
   // Instruction check from decode
   input wire logic insn_valid_i,
   input wire logic insn_high_cp_i,
   input wire logic insn_priv_i,
   input wire logic insn_simd_i,
   input wire logic insn_simd_only_i,
   input wire logic insn_upper_dreg_i,
   input wire logic insn_convert_i,
   input wire logic insn_enable_exempt_i,
   input wire cag_pkg::fmt_e insn_fmt_i,
   output logic insn_done_o,
   output logic insn_undef_o,
   // Half-precision conversion
   input wire logic conv_valid_i,
   input wire logic conv_to_single_i,
   input wire logic alt_half_mode_i,
   input wire logic [cag_pkg::WORD_W-1:0] conv_data_i,
   output logic conv_done_o,
   output logic [cag_pkg::WORD_W-1:0] conv_result_o,
   // Live view of the effective controls
   output logic simd_only_disable_o,
   output logic upper_dreg_disable_o
);
   import cag_pkg::*;

   // Bits this block owns; other coprocessors' bits are never stored.
   localparam logic [31:0] WRITE_MASK = DISABLE_MASK
      | (HIGH_IMPLEMENTED ? HIGH_PERM_MASK : 32'h0)
      | (LOW_IMPLEMENTED ? LOW_PERM_MASK : 32'h0);

   logic [31:0] written_q, written_d;
   logic [31:0] effective_q, effective_d;
   logic sc_hit_q, sc_hit_d;
   logic sc_undef_q, sc_undef_d;
   logic [31:0] sc_rdata_q, sc_rdata_d;
   logic insn_done_q, insn_done_d;
   logic insn_undef_q, insn_undef_d;
   logic sel_hit;
   logic [1:0] perm;
   logic perm_ok;
   logic fmt_ok;
   logic block;

   conv_if cv ();

   half_converter u_conv (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .cv(cv.converter)
   );

   assign cv.req = conv_valid_i;
   assign cv.to_single = conv_to_single_i;
   assign cv.alt_half = alt_half_mode_i;
   assign cv.operand = conv_data_i;
   assign conv_done_o = cv.done;
   assign conv_result_o = cv.result;

   assign sc_hit_o = sc_hit_q;
   assign sc_undef_o = sc_undef_q;
   assign sc_rdata_o = sc_rdata_q;
   assign insn_done_o = insn_done_q;
   assign insn_undef_o = insn_undef_q;
   assign simd_only_disable_o = effective_q[SIMD_ONLY_DISABLE_BIT];
   assign upper_dreg_disable_o = effective_q[UPPER_DREG_DISABLE_BIT];

   // Register access state.
   always_comb begin
      written_d = written_q;
      effective_d = effective_q;
      sc_hit_d = 1'b0;
      sc_undef_d = 1'b0;
      sc_rdata_d = '0;
      sel_hit = sc_valid_i && sc_crn_i == SEL_CRN && sc_op1_i == SEL_OP1
         && sc_crm_i == SEL_CRM && sc_op2_i == SEL_OP2;
      if (sel_hit) begin
         sc_hit_d = 1'b1;
         if (!sc_priv_i) begin
            // User-mode access is refused and nothing changes.
            sc_undef_d = 1'b1;
         end else if (sc_write_i) begin
            written_d = sc_wdata_i & WRITE_MASK;
         end else begin
            sc_rdata_d = written_q;
         end
      end
      // The gate only sees a new value once a barrier retires, so decode in
      // flight keeps the old permissions. A write in the barrier cycle counts.
      if (isb_i) begin
         effective_d = written_d;
      end
      if (rst_i) begin
         written_d = ACCESS_CONTROL_RESET;
         effective_d = ACCESS_CONTROL_RESET;
         sc_hit_d = 1'b0;
         sc_undef_d = 1'b0;
         sc_rdata_d = '0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      written_q <= written_d;
      effective_q <= effective_d;
      sc_hit_q <= sc_hit_d;
      sc_undef_q <= sc_undef_d;
      sc_rdata_q <= sc_rdata_d;
   end

   // Instruction gate state.
   always_comb begin
      // Fields are kept equal by software; each instruction uses its own field.
      perm = insn_high_cp_i ? effective_q[HIGH_PERM_LSB +: 2]
                            : effective_q[LOW_PERM_LSB +: 2];
      unique case (perm)
         PERM_DENIED: perm_ok = 1'b0;
         PERM_PRIV_ONLY: perm_ok = insn_priv_i;
         PERM_RESERVED: perm_ok = 1'b0;
         PERM_FULL: perm_ok = 1'b1;
      endcase
      // Integer operands pass as two's complement bit patterns, so signed and
      // unsigned forms need no separate format check.
      unique case (insn_fmt_i)
         FMT_INT8, FMT_INT16, FMT_INT64, FMT_POLY8, FMT_POLY16: fmt_ok = insn_simd_i;
         FMT_INT32: fmt_ok = insn_simd_i || insn_convert_i;
         FMT_SINGLE: fmt_ok = 1'b1;
         FMT_DOUBLE: fmt_ok = !insn_simd_i;
         FMT_HALF: fmt_ok = insn_convert_i;
         default: fmt_ok = 1'b0;
      endcase
      block = !perm_ok || !fmt_ok
         || (effective_q[SIMD_ONLY_DISABLE_BIT] && insn_simd_only_i)
         || (effective_q[UPPER_DREG_DISABLE_BIT] && !insn_simd_i
             && insn_upper_dreg_i)
         || (!fp_global_enable_i && !(insn_enable_exempt_i && insn_priv_i));
      insn_done_d = insn_valid_i;
      insn_undef_d = insn_valid_i && block;
      if (rst_i) begin
         insn_done_d = 1'b0;
         insn_undef_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      insn_done_q <= insn_done_d;
      insn_undef_q <= insn_undef_d;
   end
endmodule

// >>> tb/gate_monitor.sv
// Checker for the coprocessor access gate, bound to the gate's ports.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
module gate_monitor
   import cag_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic sc_valid_i,
   input wire logic sc_priv_i,
   input wire logic [3:0] sc_crn_i,
   input wire logic [2:0] sc_op1_i,
   input wire logic [3:0] sc_crm_i,
   input wire logic [2:0] sc_op2_i,
   input wire logic sc_hit_o,
   input wire logic sc_undef_o,
   input wire logic [cag_pkg::WORD_W-1:0] sc_rdata_o,
   // Barrier, instruction check and live controls
   input wire logic isb_i,
   input wire logic insn_valid_i,
   input wire logic insn_simd_i,
   input wire logic insn_simd_only_i,
   input wire logic insn_upper_dreg_i,
   input wire logic insn_convert_i,
   input wire cag_pkg::fmt_e insn_fmt_i,
   input wire logic insn_done_o,
   input wire logic insn_undef_o,
   input wire logic simd_only_disable_o,
   input wire logic upper_dreg_disable_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_sel_main;
      sc_valid_i && sc_crn_i == SEL_CRN && sc_op1_i == SEL_OP1 && sc_crm_i == SEL_CRM
         && sc_op2_i == SEL_OP2;
   endsequence
   sequence s_sel_ns;
      sc_valid_i && sc_crn_i == SEL_CRN && sc_crm_i == SEL_CRM_NONSECURE;
   endsequence
   a_select_hit: assert property (s_sel_main |=> sc_hit_o)
      else $error("selector did not hit");
   a_nonsecure_miss: assert property (s_sel_ns |=> !sc_hit_o)
      else $error("nonsecure selector hit");
   a_user_refused: assert property (
      s_sel_main ##0 !sc_priv_i |=> sc_undef_o && sc_rdata_o == '0)
      else $error("user access not refused");
   a_spare_bits_zero: assert property (
      sc_hit_o |-> (sc_rdata_o & ~(DISABLE_MASK | HIGH_PERM_MASK | LOW_PERM_MASK)) == '0)
      else $error("spare bits not zero");
   a_insn_answer: assert property (insn_valid_i |=> insn_done_o)
      else $error("instruction check unanswered");
   a_simd_block: assert property (
      insn_valid_i && simd_only_disable_o && insn_simd_only_i |=> insn_undef_o)
      else $error("simd only encoding not blocked");
   a_upper_block: assert property (
      insn_valid_i && upper_dreg_disable_o && !insn_simd_i
      && insn_upper_dreg_i |=> insn_undef_o)
      else $error("upper register access not blocked");
   a_half_convert: assert property (
      insn_valid_i && insn_fmt_i == FMT_HALF && !insn_convert_i |=> insn_undef_o)
      else $error("half arithmetic not refused");
   a_barrier_hold: assert property (!isb_i |=> $stable({simd_only_disable_o, upper_dreg_disable_o}))
      else $error("controls changed without barrier");
   a_reset_clear: assert property (disable iff (1'b0)
      rst_i |=> !sc_hit_o && !simd_only_disable_o && !upper_dreg_disable_o)
      else $error("reset did not clear outputs");
endmodule
bind coprocessor_access_gate gate_monitor i_gate_monitor (.*);

// >>> tb/core_decode_model.sv
// Model of the core's decode and exception side that issues instruction checks.
// Assumes requests are changed one time unit after the rising clock edge.
`timescale 1ns/1ps
module core_decode_model
   import cag_pkg::*;
(
   // Clock
   input wire logic sys_clk_i,
   // Barrier and global enable
   output logic isb_o,
   output logic fp_global_enable_o,
   // Instruction check request
   output logic insn_valid_o,
   output logic [6:0] insn_qual_o,
   output cag_pkg::fmt_e insn_fmt_o
);
   initial begin
      {isb_o, fp_global_enable_o, insn_valid_o, insn_qual_o} = '0;
      insn_fmt_o = FMT_SINGLE;
   end
   // Software decides when the global enable is raised.
   task automatic set_enable(input logic en);
      @(posedge sys_clk_i);
      #1 fp_global_enable_o = en;
   endtask
   // Dependent checks only follow a barrier pulse after a control write.
   task automatic barrier();
      @(posedge sys_clk_i);
      #1 isb_o = 1'b1;
      @(posedge sys_clk_i);
      #1 isb_o = 1'b0;
   endtask
   // Qualifiers are inverted once released, so stale values are never reused.
   task automatic issue(input logic [6:0] q, input fmt_e f);
      @(posedge sys_clk_i);
      #1 insn_qual_o = q;
      insn_fmt_o = f;
      insn_valid_o = 1'b1;
      @(posedge sys_clk_i);
      #1 insn_valid_o = 1'b0;
      insn_qual_o = ~q;
   endtask
endmodule

// >>> tb/tb.sv
// Self-checking testbench of the coprocessor access gate.
// Assumes a 25 MHz core clock and the decode model on the far side.
`timescale 1ns/1ps
module tb;
   import cag_pkg::*;
   logic sys_clk_i = 1'b0, rst_i = 1'b1, sc_valid_i = 1'b0, sc_write_i = 1'b0, sc_priv_i = 1'b0;
   logic [3:0] sc_crn_i = SEL_CRN, sc_crm_i = SEL_CRM;
   logic [2:0] sc_op1_i = SEL_OP1, sc_op2_i = SEL_OP2;
   logic [31:0] sc_wdata_i = '0, conv_data_i = '0, sc_rdata_o, conv_result_o;
   logic conv_valid_i = 1'b0, conv_to_single_i = 1'b0, alt_half_mode_i = 1'b0;
   logic sc_hit_o, sc_undef_o, isb_i, fp_global_enable_i, insn_valid_i, insn_done_o;
   logic insn_undef_o, conv_done_o, simd_only_disable_o, upper_dreg_disable_o;
   logic insn_high_cp_i, insn_priv_i, insn_simd_i, insn_simd_only_i, insn_upper_dreg_i;
   logic insn_convert_i, insn_enable_exempt_i;
   logic [1:0] pm;
   fmt_e insn_fmt_i;
   int mismatches = 0, checks = 0;
   coprocessor_access_gate i_coprocessor_access_gate (.*);
   core_decode_model i_core_decode_model (.sys_clk_i(sys_clk_i), .isb_o(isb_i),
      .fp_global_enable_o(fp_global_enable_i), .insn_valid_o(insn_valid_i),
      .insn_qual_o({insn_high_cp_i, insn_priv_i, insn_simd_i, insn_simd_only_i,
         insn_upper_dreg_i, insn_convert_i, insn_enable_exempt_i}), .insn_fmt_o(insn_fmt_i));
   always #20 sys_clk_i = ~sys_clk_i;
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Expected answer packs hit, refusal and read data.
   task automatic acc(input logic w, p, input logic [3:0] crm, input logic [31:0] d,
         input logic [33:0] e);
      @(posedge sys_clk_i);
      #1 {sc_write_i, sc_priv_i, sc_crm_i, sc_wdata_i} = {w, p, crm, d};
      sc_valid_i = 1'b1;
      @(posedge sys_clk_i);
      #1 sc_valid_i = 1'b0;
      sc_wdata_i = ~d;
      check(64'({sc_hit_o, sc_undef_o, sc_rdata_o}), 64'(e));
   endtask
   task automatic ins(input logic [6:0] q, input fmt_e f, input logic u);
      i_core_decode_model.issue(q, f);
      check(64'({insn_done_o, insn_undef_o}), 64'({1'b1, u}));
   endtask
   task automatic cv(input logic s, a, input logic [31:0] d, e);
      @(posedge sys_clk_i);
      #1 {conv_to_single_i, alt_half_mode_i, conv_data_i, conv_valid_i} = {s, a, d, 1'b1};
      @(posedge sys_clk_i);
      #1 conv_valid_i = 1'b0;
      check(64'({conv_done_o, conv_result_o}), 64'({1'b1, e}));
   endtask
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      mismatches++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge sys_clk_i);
      #1 rst_i = 1'b0;
      acc(0, 1, SEL_CRM, 0, {2'b10, ACCESS_CONTROL_RESET});
      acc(1, 1, SEL_CRM, 32'hffff_ffff, {2'b10, 32'h0});
      acc(0, 1, SEL_CRM, 0, {2'b10, 32'hc0f0_0000});
      acc(1, 0, SEL_CRM, 0, {2'b11, 32'h0});
      acc(0, 0, SEL_CRM, 0, {2'b11, 32'h0});
      acc(0, 1, SEL_CRM_NONSECURE, 0, {2'b00, 32'h0});
      acc(0, 1, SEL_CRM, 0, {2'b10, 32'hc0f0_0000});
      check(64'({simd_only_disable_o, upper_dreg_disable_o}), 64'h0);
      i_core_decode_model.barrier();
      check(64'({simd_only_disable_o, upper_dreg_disable_o}), 64'h3);
      i_core_decode_model.set_enable(1'b1);
      for (int i = 0; i < 8; i++) begin
         pm = i[2:1];
         acc(1, 1, SEL_CRM, {8'h0, pm, pm, 20'h0}, {2'b10, 32'h0});
         i_core_decode_model.barrier();
         ins({i[1], i[0], 5'b0}, FMT_SINGLE, pm == PERM_DENIED || pm == PERM_RESERVED
            || (pm == PERM_PRIV_ONLY && !i[0]));
      end
      acc(1, 1, SEL_CRM, 32'h80f0_0000, {2'b10, 32'h0});
      i_core_decode_model.barrier();
      ins(7'b0111000, FMT_SINGLE, 1'b1);
      ins(7'b0100100, FMT_DOUBLE, 1'b0);
      acc(1, 1, SEL_CRM, 32'h40f0_0000, {2'b10, 32'h0});
      i_core_decode_model.barrier();
      ins(7'b0111000, FMT_SINGLE, 1'b0);
      ins(7'b0100100, FMT_DOUBLE, 1'b1);
      ins(7'b0110100, FMT_SINGLE, 1'b0);
      ins(7'b0110000, FMT_DOUBLE, 1'b1);
      ins(7'b0100000, FMT_INT8, 1'b1);
      ins(7'b0110000, FMT_POLY16, 1'b0);
      ins(7'b0100000, FMT_INT32, 1'b1);
      ins(7'b0100010, FMT_INT32, 1'b0);
      ins(7'b0100000, FMT_HALF, 1'b1);
      ins(7'b0110010, FMT_HALF, 1'b0);
      i_core_decode_model.set_enable(1'b0);
      ins(7'b0100000, FMT_SINGLE, 1'b1);
      ins(7'b0100001, FMT_SINGLE, 1'b0);
      ins(7'b0000001, FMT_SINGLE, 1'b1);
      cv(1, 0, 32'h3c00, 32'h3f80_0000);
      cv(0, 0, 32'h3f80_0000, 32'h3c00);
      cv(1, 1, 32'h7c00, 32'h4780_0000);
      cv(0, 1, 32'h7f80_0000, 32'h7fff);
      cv(0, 0, 32'h7f80_0000, 32'h7c00);
      @(posedge sys_clk_i);
      #1 rst_i = 1'b1;
      @(posedge sys_clk_i);
      #1 rst_i = 1'b0;
      acc(0, 1, SEL_CRM, 0, {2'b10, 32'h0});
      check(64'({simd_only_disable_o, upper_dreg_disable_o}), 64'h0);
      complete_run();
   end
endmodule
